// file: cecs_pkg.sv
// shared constants, register map and types of the charger emulation cycle sequencer
package cecs_pkg;

  // clock and timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1000;
  localparam int EMRST_HOLD_MS   = 100;
  localparam int EMRST_HOLD_CYC  = EMRST_HOLD_MS * CYC_PER_MS;
  localparam int EM_TIMEOUT_MS   = 1000;
  localparam int EM_TIMEOUT_CYC  = EM_TIMEOUT_MS * CYC_PER_MS;
  localparam int SETTLE_MS       = 10;
  localparam int SETTLE_CYC      = SETTLE_MS * CYC_PER_MS;

  // current figures in mA
  localparam logic [11:0] CC_MAX_MA      = 12'h5DC;
  localparam logic [11:0] CURRENT_LIMIT_SETTING_RST_MA    = 12'h5DC;
  localparam logic [11:0] THRESH_RST_MA  = 12'h064;

  // register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_THRESH = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_PASSES = 12'h00C;

  // field positions
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_CURRENT_LIMIT_SETTING_LSB   = 16;
  localparam int STAT_PROF_LSB   = 0;
  localparam int STAT_STATE_LSB  = 4;
  localparam int STAT_DCP_BIT    = 8;
  localparam int STAT_ACC_BIT    = 9;
  localparam int STAT_DCE_BIT    = 10;
  localparam int STAT_PWR_BIT    = 11;
  localparam int STAT_ATT_BIT    = 12;
  localparam int STAT_CHG_BIT    = 13;
  localparam logic CTRL_EN_RST   = 1'b1;

  // index of each synchronised pin
  localparam int PIN_PWR = 0;
  localparam int PIN_EM  = 1;
  localparam int PIN_MA  = 2;
  localparam int PIN_MB  = 3;
  localparam int PIN_ATT = 4;
  localparam int PIN_N   = 5;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_EMRST  = 3'b001,
    ST_SETUP  = 3'b010,
    ST_SETTLE = 3'b011,
    ST_APPLY  = 3'b100,
    ST_ACCEPT = 3'b101,
    ST_OTHER  = 3'b110
  } cecs_state_e;

  // codes follow the cycle order, so an increment walks the sequence and wraps
  typedef enum logic [2:0] {
    PR_LEG1 = 3'b000,
    PR_DCP  = 3'b001,
    PR_LEG2 = 3'b010,
    PR_LEG3 = 3'b011,
    PR_LEG4 = 3'b100,
    PR_LEG5 = 3'b101,
    PR_LEG6 = 3'b110,
    PR_LEG7 = 3'b111
  } cecs_prof_e;

  // data line drive; the profile number selects the level of src and div
  typedef enum logic [1:0] {
    DRV_NONE  = 2'b00,
    DRV_SRC   = 2'b01,
    DRV_DIV   = 2'b10,
    DRV_900MV = 2'b11
  } cecs_drive_e;

  typedef enum logic [2:0] {
    MODE_PASS = 3'b000,
    MODE_DCP  = 3'b001,
    MODE_SDP  = 3'b010,
    MODE_CDP  = 3'b011,
    MODE_DCE  = 3'b100
  } cecs_mode_e;

endpackage : cecs_pkg

// file: cecs_sync3.sv
// three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module cecs_sync3 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[i]     <= 1'b0;
          s2_q[i]     <= 1'b0;
          s3_q[i]     <= 1'b0;
          pin_sync[i] <= 1'b0;
        end else begin
          s1_q[i] <= pin_async[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // a change counts only once stages two and three agree
          if (s2_q[i] == s3_q[i]) begin
            pin_sync[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule : cecs_sync3

// file: cecs_seq.sv
// dedicated charger emulation cycle sequencer with apb control registers
// What this block does
// - before each profile: switch open, vbus to ground via 100 ohm, hold, reclose
// - during emulation reset pull both data lines low through 15 kohm
// - cycle order: legacy 1, dcp, legacy 2, 3, 4, 5, 6, 7
// - no profile charges: reset and restart while power enable stays on
// - no usb data path while in cycle mode
// - while a profile is applied: cc limit if setting at most 1.5 A, else trip
// - pass-through and sdp use trip; dcp and cdp use cc if at most 1.5 A
// - dcp charging: set dcp flag, keep short, switch open, cc limiting if setting at most 1.5 A, else trip
// - dcp not charging: drop it and advance to the next profile
// - emulation timeout timer runs while dcp is applied inside the cycle
// - legacy 2: short first, then vbus; charging keeps short, cc limiting if setting at most 1.5 A, else trip
// - legacy 2 not charging: remove short, reset, next profile
// - legacy 1,3,4,6: drive both lines before vbus; accept with trip
// - legacy 5: 900 mV on both lines before vbus; accept with trip
// - legacy 7: divider on d+ only before vbus; accept with trip
// - keep cycling with no device; no profile is assumed at attach
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cecs_seq
  import cecs_pkg::*;
#(
  parameter int          EMRST_CYC   = EMRST_HOLD_CYC,
  parameter int          TIMEOUT_CYC = EM_TIMEOUT_CYC,
  parameter int          SETTLE_CY   = SETTLE_CYC,
  parameter logic [11:0] CHG_THRESH  = THRESH_RST_MA
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_power_enable,
  input  wire logic        emulation_enable,
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  input  wire logic        attach_detect_enable,
  input  wire logic [11:0] port_current_ma,
  output logic             vbus_switch_close,
  output logic             vbus_discharge_en,
  output logic             data_pulldown_en,
  output logic             line_short_en,
  output logic             hs_switch_close,
  output logic             cc_limit_sel,
  output logic [1:0]       port_dplus_line,
  output logic [1:0]       port_dminus_line,
  output logic [2:0]       drive_profile,
  output logic             dcp_detected,
  output logic             charge_accepted
);

  // pin synchronisation
  logic [PIN_N-1:0] pins_raw;
  logic [PIN_N-1:0] pins_s;

  assign pins_raw[PIN_PWR] = port_power_enable;
  assign pins_raw[PIN_EM]  = emulation_enable;
  assign pins_raw[PIN_MA]  = mode_select_a;
  assign pins_raw[PIN_MB]  = mode_select_b;
  assign pins_raw[PIN_ATT] = attach_detect_enable;

  cecs_sync3 #(
    .W (PIN_N)
  ) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (pins_raw),
    .pin_sync  (pins_s)
  );

  wire pwr_on = pins_s[PIN_PWR];
  wire em_s   = pins_s[PIN_EM];
  wire ma_s   = pins_s[PIN_MA];
  wire mb_s   = pins_s[PIN_MB];

  // mode decode; both encodings with b low and emulation high select the cycle
  cecs_mode_e mode;
  wire        is_dce = ~mb_s & em_s;
  assign mode = is_dce                 ? MODE_DCE :
                ( mb_s & em_s & ~ma_s) ? MODE_DCP :
                ( mb_s & em_s &  ma_s) ? MODE_CDP :
                (~mb_s & ~em_s & ma_s) ? MODE_SDP : MODE_PASS;

  // registers
  logic        en_q;
  logic [11:0] current_limit_setting_q;
  logic [11:0] thresh_q;
  logic [15:0] passes_q;
  logic [15:0] passes_d;

  wire acc_ph    = psel & penable;
  wire hit_ctrl  = (paddr == REG_CTRL);
  wire hit_thr   = (paddr == REG_THRESH);
  wire hit_stat  = (paddr == REG_STATUS);
  wire hit_pass  = (paddr == REG_PASSES);
  wire hit_any   = hit_ctrl | hit_thr | hit_stat | hit_pass;
  wire wr_ctrl   = acc_ph & pwrite & hit_ctrl;
  wire wr_thr    = acc_ph & pwrite & hit_thr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q     <= CTRL_EN_RST;
      current_limit_setting_q   <= CURRENT_LIMIT_SETTING_RST_MA;
      thresh_q <= CHG_THRESH;
    end else begin
      if (wr_ctrl) begin
        en_q   <= pwdata[CTRL_EN_BIT];
        current_limit_setting_q <= pwdata[CTRL_CURRENT_LIMIT_SETTING_LSB +: 12];
      end
      if (wr_thr) begin
        thresh_q <= pwdata[11:0];
      end
    end
  end

  // sequencer state
  cecs_state_e state_q;
  cecs_state_e state_d;
  cecs_prof_e  prof_q;
  cecs_prof_e  prof_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        dcp_q;
  logic        dcp_d;

  wire cc_ok    = (current_limit_setting_q <= CC_MAX_MA);
  wire charging = (port_current_ma >= thresh_q);
  wire run_ok   = pwr_on & is_dce & en_q;
  wire cnt_done = (cnt_q == 32'h0000_0000);

  always_comb begin
    state_d  = state_q;
    prof_d   = prof_q;
    cnt_d    = cnt_done ? cnt_q : cnt_q - 32'h0000_0001;
    dcp_d    = dcp_q;
    passes_d = passes_q;
    if (!pwr_on) begin
      // power enable low aborts everything
      state_d = ST_IDLE;
      prof_d  = PR_LEG1;
      dcp_d   = 1'b0;
    end else if (!is_dce) begin
      state_d = ST_OTHER;
      prof_d  = PR_LEG1;
      dcp_d   = 1'b0;
    end else if (!en_q) begin
      state_d = ST_IDLE;
      prof_d  = PR_LEG1;
      dcp_d   = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_OTHER: begin
          state_d = ST_EMRST;
          prof_d  = PR_LEG1;
          cnt_d   = 32'(EMRST_CYC - 1);
        end
        ST_EMRST: begin
          if (cnt_done) begin
            state_d = ST_SETUP;
          end
        end
        ST_SETUP: begin
          // line levels or short are in place one cycle ahead of vbus
          state_d = ST_SETTLE;
          cnt_d   = 32'(SETTLE_CY - 1);
        end
        ST_SETTLE: begin
          if (cnt_done) begin
            state_d = ST_APPLY;
            cnt_d   = 32'(TIMEOUT_CYC - 1);
          end
        end
        ST_APPLY: begin
          if (charging) begin
            state_d = ST_ACCEPT;
            dcp_d   = (prof_q == PR_DCP);
          end else if (cnt_done) begin
            // drop the profile, reset, then the next one; wraps to restart
            state_d = ST_EMRST;
            prof_d  = cecs_prof_e'(prof_q + 3'h1);
            cnt_d   = 32'(EMRST_CYC - 1);
            if (prof_q == PR_LEG7) begin
              passes_d = passes_q + 16'h0001;
            end
          end
        end
        ST_ACCEPT: begin
          state_d = ST_ACCEPT;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_IDLE;
      prof_q   <= PR_LEG1;
      cnt_q    <= 32'h0000_0000;
      dcp_q    <= 1'b0;
      passes_q <= 16'h0000;
    end else begin
      state_q  <= state_d;
      prof_q   <= prof_d;
      cnt_q    <= cnt_d;
      dcp_q    <= dcp_d;
      passes_q <= passes_d;
    end
  end

  // per-profile line drive
  cecs_drive_e dp_prof;
  cecs_drive_e dm_prof;
  logic        short_prof;
  logic        cc_accept;

  always_comb begin
    dp_prof    = DRV_NONE;
    dm_prof    = DRV_NONE;
    short_prof = 1'b0;
    cc_accept  = 1'b0;
    unique case (prof_q)
      PR_DCP: begin
        short_prof = 1'b1;
        cc_accept  = cc_ok;
      end
      PR_LEG2: begin
        short_prof = 1'b1;
        cc_accept  = cc_ok;
      end
      PR_LEG1, PR_LEG3, PR_LEG4, PR_LEG6: begin
        dp_prof = DRV_SRC;
        dm_prof = DRV_SRC;
      end
      PR_LEG5: begin
        dp_prof = DRV_900MV;
        dm_prof = DRV_900MV;
      end
      PR_LEG7: begin
        dp_prof = DRV_DIV;
      end
    endcase
  end

  // output next values
  wire in_emrst  = (state_d == ST_EMRST);
  wire applying  = (state_d == ST_SETUP) | (state_d == ST_SETTLE) |
                   (state_d == ST_APPLY) | (state_d == ST_ACCEPT);
  wire vbus_on   = (state_d == ST_SETTLE) | (state_d == ST_APPLY) |
                   (state_d == ST_ACCEPT);
  wire accepted  = (state_d == ST_ACCEPT);
  wire other_on  = (state_d == ST_OTHER);
  wire other_hs  = (mode == MODE_PASS) | (mode == MODE_SDP) | (mode == MODE_CDP);
  wire other_cc  = ((mode == MODE_DCP) | (mode == MODE_CDP)) & cc_ok;

  logic       sw_d;
  logic       dis_d;
  logic       pd_d;
  logic       short_d;
  logic       hs_d;
  logic       cc_d;
  logic [1:0] dp_d;
  logic [1:0] dm_d;

  assign sw_d    = vbus_on | other_on;
  assign dis_d   = in_emrst;
  assign pd_d    = in_emrst;
  assign short_d = (applying & short_prof) | (other_on & (mode == MODE_DCP));
  // cycle mode never closes the data path; dcp keeps it open
  assign hs_d    = other_on & other_hs;
  assign cc_d    = accepted ? cc_accept :
                   applying ? cc_ok :
                   other_on & other_cc;
  assign dp_d    = applying ? dp_prof : DRV_NONE;
  assign dm_d    = applying ? dm_prof : DRV_NONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_switch_close <= 1'b0;
      vbus_discharge_en <= 1'b0;
      data_pulldown_en  <= 1'b0;
      line_short_en     <= 1'b0;
      hs_switch_close   <= 1'b0;
      cc_limit_sel      <= 1'b0;
      port_dplus_line   <= DRV_NONE;
      port_dminus_line  <= DRV_NONE;
      drive_profile     <= PR_LEG1;
      dcp_detected      <= 1'b0;
      charge_accepted   <= 1'b0;
    end else begin
      vbus_switch_close <= sw_d;
      vbus_discharge_en <= dis_d;
      data_pulldown_en  <= pd_d;
      line_short_en     <= short_d;
      hs_switch_close   <= hs_d;
      cc_limit_sel      <= cc_d;
      port_dplus_line   <= dp_d;
      port_dminus_line  <= dm_d;
      drive_profile     <= prof_d;
      dcp_detected      <= dcp_d;
      charge_accepted   <= accepted;
    end
  end

  // apb read side; zero wait states
  logic [31:0] status_w;

  always_comb begin
    status_w                           = 32'h0000_0000;
    status_w[STAT_PROF_LSB +: 3]       = prof_q;
    status_w[STAT_STATE_LSB +: 3]      = state_q;
    status_w[STAT_DCP_BIT]             = dcp_q;
    status_w[STAT_ACC_BIT]             = (state_q == ST_ACCEPT);
    status_w[STAT_DCE_BIT]             = is_dce;
    status_w[STAT_PWR_BIT]             = pwr_on;
    status_w[STAT_ATT_BIT]             = pins_s[PIN_ATT];
    status_w[STAT_CHG_BIT]             = charging;
  end

  wire [31:0] ctrl_w   = {4'h0, current_limit_setting_q, 15'h0000, en_q};
  wire [31:0] thr_w    = {20'h00000, thresh_q};
  wire [31:0] pass_w   = {16'h0000, passes_q};
  wire [31:0] rd_mux   = hit_ctrl ? ctrl_w :
                         hit_thr  ? thr_w :
                         hit_stat ? status_w :
                         hit_pass ? pass_w : 32'h0000_0000;

  wire rd_setup = psel & ~penable & ~pwrite;

  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~hit_any;

  // read data is caught in the setup phase and stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule : cecs_seq

// file: cecs_seq_properties.sv
// assertion checker for the charger emulation cycle sequencer
`timescale 1ns/1ps
module cecs_seq_chk
  import cecs_pkg::*;
#(
  parameter int EMRST_CYC   = 8,
  parameter int TIMEOUT_CYC = 40,
  parameter int SETTLE_CY   = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        vbus_switch_close,
  input wire logic        vbus_discharge_en,
  input wire logic        data_pulldown_en,
  input wire logic        line_short_en,
  input wire logic        hs_switch_close,
  input wire logic        cc_limit_sel,
  input wire logic [1:0]  port_dplus_line,
  input wire logic [1:0]  port_dminus_line,
  input wire logic [2:0]  drive_profile,
  input wire logic        dcp_detected,
  input wire logic        charge_accepted
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int ON_MAX = SETTLE_CY + TIMEOUT_CYC + 1;
  logic [11:0] current_limit_setting_q;
  int          hold_q;
  int          on_q;
  // cyc_q marks a profile begun by an emulation reset; it drops once the switch is open, d+ is undriven and there is no short
  logic        cyc_q;
  wire         cc_ok  = current_limit_setting_q <= CC_MAX_MA;
  wire         cc_acc = drive_profile == PR_DCP || drive_profile == PR_LEG2;
  wire         in_cyc = cyc_q && vbus_switch_close && !hs_switch_close && !charge_accepted;
  // shadow of the limit setting and lengths of reset and applied phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_limit_setting_q <= CURRENT_LIMIT_SETTING_RST_MA;
      hold_q <= 0;
      on_q <= 0;
      cyc_q <= 1'b0;
    end else begin
      if (vbus_discharge_en) cyc_q <= 1'b1;
      else if (!vbus_switch_close && port_dplus_line == DRV_NONE && !line_short_en)
        cyc_q <= 1'b0;
      if (psel && penable && pwrite && paddr == REG_CTRL) current_limit_setting_q <= pwdata[CTRL_CURRENT_LIMIT_SETTING_LSB +: 12];
      if ($rose(vbus_discharge_en)) hold_q <= 1;
      else if (vbus_discharge_en) hold_q <= hold_q + 1;
      on_q <= in_cyc ? on_q + 1 : 0;
    end
  end
  a_reset_opens: assert property (vbus_discharge_en |-> !vbus_switch_close && data_pulldown_en)
    else $error("switch closed or no pulldown in reset");
  a_hold_count: assert property ($rose(vbus_switch_close) && cyc_q |-> hold_q == EMRST_CYC)
    else $error("reset hold length wrong");
  a_reset_clears: assert property (vbus_discharge_en |-> port_dplus_line == DRV_NONE && port_dminus_line == DRV_NONE && !line_short_en)
    else $error("line drive left on in reset");
  a_profile_order: assert property ($changed(drive_profile) && drive_profile != PR_LEG1 |-> drive_profile == $past(drive_profile) + 3'h1)
    else $error("profile out of order");
  a_no_data_path: assert property (port_dplus_line != DRV_NONE || charge_accepted |-> !hs_switch_close)
    else $error("data path closed in cycle");
  a_cc_applied: assert property (in_cyc |-> cc_limit_sel == cc_ok)
    else $error("limit mode wrong while applying");
  a_accept_trip: assert property (charge_accepted && !cc_acc |-> !cc_limit_sel)
    else $error("legacy accept not trip");
  a_accept_cc: assert property (charge_accepted && cc_acc |-> cc_limit_sel == cc_ok && line_short_en)
    else $error("short or limit wrong on accept");
  a_dcp_flag: assert property (charge_accepted |-> dcp_detected == (drive_profile == PR_DCP))
    else $error("dcp flag wrong");
  a_apply_bound: assert property (on_q <= ON_MAX)
    else $error("profile applied past timeout");
  a_legacy5_lines: assert property ($rose(vbus_switch_close) && drive_profile == PR_LEG5 |-> port_dplus_line == DRV_900MV && port_dminus_line == DRV_900MV)
    else $error("legacy 5 levels missing");
  c_accept: cover property ($rose(charge_accepted));
  c_dcp: cover property ($rose(dcp_detected));
  c_wrap: cover property ($changed(drive_profile) && drive_profile == PR_LEG1);
endmodule : cecs_seq_chk

bind cecs_seq cecs_seq_chk #(.EMRST_CYC(EMRST_CYC), .TIMEOUT_CYC(TIMEOUT_CYC), .SETTLE_CY(SETTLE_CY))
  u_cecs_seq_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .vbus_switch_close, .vbus_discharge_en, .data_pulldown_en, .line_short_en, .hs_switch_close,
  .cc_limit_sel, .port_dplus_line, .port_dminus_line, .drive_profile, .dcp_detected,
  .charge_accepted);

// file: cecs_dev_model.sv
// portable device model that draws charge current on one chosen profile
`timescale 1ns/1ps
module cecs_dev_model (
  input  wire logic        pclk,
  input  wire logic        vbus_switch_close,
  input  wire logic [2:0]  drive_profile,
  input  wire logic        dev_on,
  input  wire logic [2:0]  want_prof,
  output logic      [11:0] port_current_ma
);
  // idle draw with vbus only, charge draw on its own profile
  always_ff @(posedge pclk) begin
    if (vbus_switch_close && dev_on && drive_profile == want_prof) port_current_ma <= 12'h1F4;
    else port_current_ma <= vbus_switch_close ? 12'h00A : 12'h000;
  end
endmodule : cecs_dev_model

// file: cecs_seq_test.sv
// self-checking testbench of the charger emulation cycle sequencer
`timescale 1ns/1ps
module cecs_seq_test
  import cecs_pkg::*;
;
  logic pclk = 0, presetn, psel, penable, pwrite, pready, pslverr;
  logic port_power_enable, emulation_enable, mode_select_a, mode_select_b;
  logic attach_detect_enable, vbus_switch_close, vbus_discharge_en, data_pulldown_en;
  logic line_short_en, hs_switch_close, cc_limit_sel, dcp_detected, charge_accepted, dev_on;
  logic [11:0] paddr, port_current_ma, lim;
  logic [31:0] pwdata, prdata;
  logic [1:0]  port_dplus_line, port_dminus_line;
  logic [2:0]  drive_profile, want_prof;
  int          fails = 0, samples_checked = 0, i;
  always #10 pclk = ~pclk;
  cecs_seq #(.EMRST_CYC(8), .TIMEOUT_CYC(40), .SETTLE_CY(4)) u_cecs_seq (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_power_enable,
    .emulation_enable, .mode_select_a, .mode_select_b, .attach_detect_enable, .port_current_ma,
    .vbus_switch_close, .vbus_discharge_en, .data_pulldown_en, .line_short_en, .hs_switch_close,
    .cc_limit_sel, .port_dplus_line, .port_dminus_line, .drive_profile, .dcp_detected,
    .charge_accepted);
  cecs_dev_model u_cecs_dev_model (.pclk, .vbus_switch_close, .drive_profile, .dev_on,
    .want_prof, .port_current_ma);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] ed, input logic ee, input string nm);
    logic [31:0] r;
    logic        e;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (!w) chk(nm, ed, r);
    chk("pslverr", {31'h0, ee}, {31'h0, e});
  endtask : xfer
  task automatic wait_close;
    int n;
    for (n = 0; n < 300 && vbus_switch_close !== 1'b0; n++) @(posedge pclk);
    if (i > 0) chk("reset", 2'b11, {vbus_discharge_en, data_pulldown_en});
    for (n = 0; n < 300 && vbus_switch_close !== 1'b1; n++) @(posedge pclk);
  endtask : wait_close
  function automatic logic [4:0] exp_lines(input logic [2:0] p);
    case (p)
      PR_DCP, PR_LEG2: return {1'b1, DRV_NONE, DRV_NONE};
      PR_LEG5: return {1'b0, DRV_900MV, DRV_900MV};
      PR_LEG7: return {1'b0, DRV_DIV, DRV_NONE};
      default: return {1'b0, DRV_SRC, DRV_SRC};
    endcase
  endfunction : exp_lines
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic power_off;
    port_power_enable <= 0;
    repeat (8) @(posedge pclk);
    chk("off", 32'h0, {vbus_switch_close, charge_accepted, dcp_detected});
  endtask : power_off
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {port_power_enable, emulation_enable, mode_select_a, mode_select_b} = '0;
    {attach_detect_enable, dev_on, want_prof} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    xfer(0, REG_CTRL, 0, 32'h05DC_0001, 0, "ctrl");
    xfer(0, REG_THRESH, 0, 32'h0000_0064, 0, "thresh");
    xfer(1, 12'h010, 32'hFFFF_FFFF, 0, 1, "unmapped");
    xfer(0, 12'h010, 0, 0, 1, "unmapped");
    $display("test registers done");
    // device draws below a raised threshold, so the cycle never settles
    xfer(1, REG_THRESH, 32'h3E8, 0, 0, "thresh");
    dev_on <= 1;
    emulation_enable <= 1;
    port_power_enable <= 1;
    for (i = 0; i < 9; i++) begin
      wait_close();
      chk("profile", i % 8, drive_profile);
      chk("lines", exp_lines(i[2:0]), {line_short_en, port_dplus_line, port_dminus_line});
      chk("hs", 0, hs_switch_close);
    end
    xfer(0, REG_PASSES, 0, 32'h1, 0, "passes");
    power_off();
    xfer(1, REG_THRESH, 32'h64, 0, 0, "thresh");
    $display("test cycling done");
    for (i = 0; i < 8; i++) begin
      lim = i[0] ? 12'h5DC : 12'h5DD;
      xfer(1, REG_CTRL, {4'h0, lim, 16'h0001}, 0, 0, "ctrl");
      want_prof <= i[2:0];
      mode_select_a <= i[0];
      attach_detect_enable <= 1;
      port_power_enable <= 1;
      repeat (1500) if (charge_accepted !== 1'b1) @(posedge pclk);
      chk("accepted", 1, charge_accepted);
      chk("profile", i, drive_profile);
      chk("cc", (i == 1 || i == 2) && lim <= CC_MAX_MA, cc_limit_sel);
      chk("dcp", i == 1, dcp_detected);
      chk("lines", exp_lines(i[2:0]), {line_short_en, port_dplus_line, port_dminus_line});
      chk("hs", 0, hs_switch_close);
      xfer(0, REG_STATUS, 0, {18'h0, 5'h1F, i == 1, 1'b0, 3'h5, 1'b0, i[2:0]}, 0, "status");
      power_off();
      $display("test accept %0d done", i);
    end
    // pass-through, sdp, dcp, cdp in turn, each on both sides of the cc limit
    for (i = 0; i < 8; i++) begin
      lim = i[0] ? 12'h5DD : 12'h5DC;
      xfer(1, REG_CTRL, {4'h0, lim, 16'h0001}, 0, 0, "ctrl");
      {mode_select_b, emulation_enable, mode_select_a} <= {i[2], i[2], i[1]};
      port_power_enable <= 1;
      repeat (10) @(posedge pclk);
      chk("other", {1'b1, i[2:1] != 2, i[2:1] == 2, i[2] && lim <= CC_MAX_MA},
          {vbus_switch_close, hs_switch_close, line_short_en, cc_limit_sel});
      power_off();
    end
    $display("test other modes done");
    final_report();
  end
  initial begin
    #(20 * 30000);
    fails++;
    final_report();
  end
endmodule : cecs_seq_test
